// [adcrt_checker.sv]
`timescale 1ns/100ps
module adcrt_checker (
   // clock and reset
   input wire        ref_clk,
   input wire        rst_n,
   // register bus
   input wire        avs_read,
   input wire        avs_write,
   input wire [31:0] avs_readdata,
   input wire        avs_waitrequest,
   input wire [1:0]  avs_response,
   // core and pins
   input wire        core_start,
   input wire        core_enable,
   input wire [7:0]  pin_raw,
   input wire [7:0]  pin_input,
   input wire [7:0]  pin_input_disable_bits
);
default clocking @(posedge ref_clk); endclocking
default disable iff (!rst_n);
property p_answer; $rose(avs_read) || $rose(avs_write) |-> ##[1:3] !avs_waitrequest; endproperty
a_answer: assert property (p_answer) else $error("no bus answer");
property p_cause; !avs_waitrequest |-> $past(avs_read || avs_write); endproperty
a_cause: assert property (p_cause) else $error("answer without request");
property p_short; !avs_waitrequest |=> avs_waitrequest; endproperty
a_short: assert property (p_short) else $error("answer held too long");
property p_refused; avs_response == 2'h2 |-> avs_readdata == 32'h0000_0000; endproperty
a_refused: assert property (p_refused) else $error("refused read carries data");
property p_upper; avs_readdata[31:8] == 24'h00_0000; endproperty
a_upper: assert property (p_upper) else $error("upper read bits set");
property p_pulse; core_start |=> !core_start; endproperty
a_pulse: assert property (p_pulse) else $error("start longer than one cycle");
property p_start_en; core_start |-> core_enable; endproperty
a_start_en: assert property (p_start_en) else $error("start while disabled");
// disable may act from either edge of its write, so only bits off in both cycles count
property p_gate; (pin_input & pin_input_disable_bits & $past(pin_input_disable_bits)) == 8'h00;
endproperty
a_gate: assert property (p_gate) else $error("disabled pin reads one");
property p_pass; (pin_input & ~$past(pin_raw)) == 8'h00; endproperty
a_pass: assert property (p_pass) else $error("pin input without pin");
c_read: cover property (avs_read && !avs_waitrequest);
c_start: cover property (core_start);
c_refused: cover property (avs_response == 2'h2);
endmodule
bind adcrt_regs adcrt_checker chk_i (.ref_clk(ref_clk), .rst_n(rst_n), .avs_read(avs_read),
   .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
   .avs_response(avs_response), .core_start(core_start), .core_enable(core_enable),
   .pin_raw(pin_raw), .pin_input(pin_input), .pin_input_disable_bits(pin_input_disable_bits));

// [adcrt_defs.vh]
`ifndef ADCRT_DEFS_VH
`define ADCRT_DEFS_VH
// register offsets (printed indices; byte address is four times the index)
`define ADCRT_IDX_INPUT_BUFFER_DISABLE 4'h1
`define ADCRT_IDX_CONV_CONTROL_B       4'h3
`define ADCRT_IDX_RESULT_LOW_BYTE      4'h4
`define ADCRT_IDX_RESULT_HIGH_BYTE     4'h5
`define ADCRT_IDX_CONV_CONTROL_A       4'h6
`define ADCRT_IDX_STATUS               4'h7
// conv_control_b fields
`define ADCRT_CB_BIPOLAR   7
`define ADCRT_CB_LEFT_ADJ  4
`define ADCRT_CB_TRIG_LO   0
// own control and status register fields
`define ADCRT_CA_ENABLE    0
`define ADCRT_CA_AUTO_TRIG 1
`define ADCRT_CA_START     2
`define ADCRT_ST_DONE      0
`define ADCRT_ST_LOCK      1
`define ADCRT_ST_BUSY      2
// reset values
`define ADCRT_RST_BYTE     8'h00
`define ADCRT_RST_RESULT   10'h000
// trigger source code and full-scale result
`define ADCRT_TRIG_FREE    3'h0
`define ADCRT_FULL_SCALE   10'h3ff
`endif

// [adcrt_present.v]
`timescale 1ns/100ps
`include "adcrt_defs.vh"
module adcrt_present (
   // stored result and format
   input  wire [9:0] conversion_result,
   input  wire       left_adjust,
   // presented bytes
   output wire [7:0] low_view,
   output wire [7:0] high_view
);
   // purely combinational so a format change shows at once
   assign high_view = left_adjust ? conversion_result[9:2]
                                  : {6'h00, conversion_result[9:8]};
   assign low_view  = left_adjust ? {conversion_result[1:0], 6'h00}
                                  : conversion_result[7:0];
endmodule

// [adcrt_regs.v]
`timescale 1ns/100ps
`include "adcrt_defs.vh"
module adcrt_regs (
   // clock and reset
   input  wire        ref_clk,
   input  wire        rst_n,
   // avalon-mm slave
   input  wire [5:0]  avs_address,
   input  wire        avs_read,
   input  wire        avs_write,
   input  wire [31:0] avs_writedata,
   input  wire [3:0]  avs_byteenable,
   output reg  [31:0] avs_readdata,
   output reg         avs_waitrequest,
   output reg  [1:0]  avs_response,
   // conversion core
   input  wire        core_done,
   input  wire [9:0]  core_raw,
   input  wire        core_negative,
   output reg         core_start,
   output reg         core_bipolar,
   output reg         core_enable,
   // peripheral interrupt flags, codes 1 to 7
   input  wire [6:0]  periph_flags,
   // port pins
   input  wire [7:0]  pin_raw,
   output reg  [7:0]  pin_input,
   output reg  [7:0]  pin_input_disable_bits
);
   reg  [7:0] conv_control_b;
   reg  [2:0] control_a;
   reg  [9:0] conversion_result;
   reg        conversion_done_flag;
   reg        read_lock;
   reg        busy;
   reg        acked;
   wire [3:0] reg_index;
   wire       access;
   wire       wr_go;
   wire       rd_go;
   wire       left_adjust;
   wire       bipolar_select;
   wire [2:0] trigger_source_sel;
   wire       auto_trigger_en;
   wire       converter_enable;
   wire       trigger_pulse;
   wire [7:0] low_view;
   wire [7:0] high_view;
   wire       mapped;
   wire       done_clear;
   reg  [9:0] next_result;
   reg  [7:0] rd_byte;

   assign reg_index          = avs_address[5:2];
   assign access             = (avs_read | avs_write) & ~acked;
   assign wr_go              = avs_write & ~acked & avs_byteenable[0];
   assign rd_go              = avs_read & ~acked;
   assign left_adjust        = conv_control_b[`ADCRT_CB_LEFT_ADJ];
   assign bipolar_select     = conv_control_b[`ADCRT_CB_BIPOLAR];
   assign trigger_source_sel = conv_control_b[`ADCRT_CB_TRIG_LO +: 3];
   assign auto_trigger_en    = control_a[`ADCRT_CA_AUTO_TRIG];
   assign converter_enable   = control_a[`ADCRT_CA_ENABLE];
   assign mapped = (reg_index == `ADCRT_IDX_INPUT_BUFFER_DISABLE) |
                   (reg_index == `ADCRT_IDX_CONV_CONTROL_B) |
                   (reg_index == `ADCRT_IDX_RESULT_LOW_BYTE) |
                   (reg_index == `ADCRT_IDX_RESULT_HIGH_BYTE) |
                   (reg_index == `ADCRT_IDX_CONV_CONTROL_A) |
                   (reg_index == `ADCRT_IDX_STATUS);
   // status bit 0 is write-one-to-clear
   assign done_clear = wr_go & (reg_index == `ADCRT_IDX_STATUS) &
                       avs_writedata[`ADCRT_ST_DONE];

   adcrt_trigger u_trigger (
      .ref_clk              (ref_clk),
      .rst_n                (rst_n),
      .auto_trigger_en      (auto_trigger_en & converter_enable),
      .trigger_source_sel   (trigger_source_sel),
      .conversion_done_flag (conversion_done_flag),
      .periph_flags         (periph_flags),
      .trigger_pulse        (trigger_pulse)
   );

   adcrt_present u_present (
      .conversion_result (conversion_result),
      .left_adjust       (left_adjust),
      .low_view          (low_view),
      .high_view         (high_view)
   );

   // result formatting from the core's raw code
   always @* begin
      if (bipolar_select) begin
         next_result = core_raw;
      end else if (core_negative) begin
         next_result = `ADCRT_FULL_SCALE;
      end else begin
         next_result = core_raw;
      end
   end

   always @* begin
      case (reg_index)
         `ADCRT_IDX_INPUT_BUFFER_DISABLE: rd_byte = pin_input_disable_bits;
         `ADCRT_IDX_CONV_CONTROL_B:       rd_byte = conv_control_b;
         `ADCRT_IDX_RESULT_LOW_BYTE:      rd_byte = low_view;
         `ADCRT_IDX_RESULT_HIGH_BYTE:     rd_byte = high_view;
         `ADCRT_IDX_CONV_CONTROL_A:       rd_byte = {5'h00, control_a};
         `ADCRT_IDX_STATUS:               rd_byte = {5'h00, busy, read_lock,
                                                     conversion_done_flag};
         default:                         rd_byte = 8'h00;
      endcase
   end

   // bus handshake: one wait cycle, answer on the second edge
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         acked           <= 1'b0;
         avs_waitrequest <= 1'b1;
         avs_readdata    <= 32'h0000_0000;
         avs_response    <= 2'b00;
      end else begin
         acked           <= access;
         avs_waitrequest <= ~access;
         if (access) begin
            avs_response <= mapped ? 2'b00 : 2'b10;
            avs_readdata <= avs_read ? {24'h00_0000, rd_byte} : 32'h0000_0000;
         end
      end
   end

   // register writes
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         conv_control_b         <= `ADCRT_RST_BYTE;
         control_a              <= 3'h0;
         pin_input_disable_bits <= `ADCRT_RST_BYTE;
      end else begin
         control_a[`ADCRT_CA_START] <= 1'b0;
         if (wr_go) begin
            case (reg_index)
               `ADCRT_IDX_INPUT_BUFFER_DISABLE: pin_input_disable_bits <= avs_writedata[7:0];
               `ADCRT_IDX_CONV_CONTROL_B:       conv_control_b <= avs_writedata[7:0];
               `ADCRT_IDX_CONV_CONTROL_A:       control_a <= avs_writedata[2:0];
               default:                         control_a <= control_a;
            endcase
         end
      end
   end

   // conversion launch and result capture
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         core_start           <= 1'b0;
         core_enable          <= 1'b0;
         core_bipolar         <= 1'b0;
         busy                 <= 1'b0;
         conversion_result    <= `ADCRT_RST_RESULT;
         conversion_done_flag <= 1'b0;
         read_lock            <= 1'b0;
      end else begin
         core_enable  <= converter_enable;
         core_bipolar <= bipolar_select;
         // start and trigger in adjacent cycles must still give a single pulse
         core_start   <= converter_enable & ~busy & ~core_start &
                         (control_a[`ADCRT_CA_START] | trigger_pulse);
         if (!converter_enable) begin
            busy <= 1'b0;
         end else if (core_start) begin
            busy <= 1'b1;
         end else if (core_done) begin
            busy <= 1'b0;
         end
         // lock set by low read, released by high read
         if (rd_go && reg_index == `ADCRT_IDX_RESULT_HIGH_BYTE) begin
            read_lock <= 1'b0;
         end else if (rd_go && reg_index == `ADCRT_IDX_RESULT_LOW_BYTE) begin
            read_lock <= 1'b1;
         end
         if (core_done && !read_lock) begin
            conversion_result <= next_result;
         end
         // set wins over a simultaneous clear
         if (core_done && !read_lock) begin
            conversion_done_flag <= 1'b1;
         end else if (done_clear) begin
            conversion_done_flag <= 1'b0;
         end
      end
   end

   // disabled pins read zero on the port
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_input <= 8'h00;
      end else begin
         pin_input <= pin_raw & ~pin_input_disable_bits;
      end
   end
endmodule

// [adcrt_trigger.v]
`timescale 1ns/100ps
`include "adcrt_defs.vh"
module adcrt_trigger (
   // clock and reset
   input  wire       ref_clk,
   input  wire       rst_n,
   // control
   input  wire       auto_trigger_en,
   input  wire [2:0] trigger_source_sel,
   input  wire       conversion_done_flag,
   input  wire [6:0] periph_flags,
   // event
   output reg        trigger_pulse
);
   wire [7:0] flag_vec;
   reg        sel_level;
   reg        prev_level;
   reg        done_prev;
   wire       conversion_done_flag_rise;
   assign flag_vec = {periph_flags, conversion_done_flag};
   always @* begin
      sel_level = flag_vec[trigger_source_sel];
   end
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         prev_level    <= 1'b0;
         trigger_pulse <= 1'b0;
      end else begin
         prev_level <= sel_level;
         // a source switch onto a set flag is seen as a rising edge
         // free running is restarted by the done flag edge, not by selection
         trigger_pulse <= auto_trigger_en & sel_level & ~prev_level &
                          ~(trigger_source_sel == `ADCRT_TRIG_FREE &
                            ~conversion_done_flag_rise);
      end
   end
   assign conversion_done_flag_rise = conversion_done_flag & ~done_prev;
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         done_prev <= 1'b0;
      end else begin
         done_prev <= conversion_done_flag;
      end
   end
endmodule

// [testbench.sv]
`timescale 1ns/100ps
module testbench;
reg         ref_clk, rst_n, avs_read, avs_write, core_done, core_negative;
reg  [5:0]  avs_address;
reg  [31:0] avs_writedata, d;
reg  [9:0]  core_raw, r;
reg  [6:0]  periph_flags;
reg  [7:0]  pin_raw, w;
reg  [15:0] e;
wire [31:0] avs_readdata;
wire        avs_waitrequest, core_start, core_bipolar, core_enable;
wire [1:0]  avs_response;
wire [7:0]  pin_input, pin_input_disable_bits;
integer     errors, n_tests, seed, cyc, starts, i;
adcrt_regs DUT (.ref_clk(ref_clk), .rst_n(rst_n), .avs_address(avs_address),
   .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
   .avs_byteenable(4'hf), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
   .avs_response(avs_response), .core_done(core_done), .core_raw(core_raw),
   .core_negative(core_negative), .core_start(core_start), .core_bipolar(core_bipolar),
   .core_enable(core_enable), .periph_flags(periph_flags), .pin_raw(pin_raw),
   .pin_input(pin_input), .pin_input_disable_bits(pin_input_disable_bits));
task close_out;
   begin
      if (errors == 0 && n_tests > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   end
endtask
task chk(input [31:0] g, input [31:0] x);
   begin
      n_tests = n_tests + 1;
      if (g !== x) begin
         errors = errors + 1;
         $display("BAD %0t got %h exp %h", $time, g, x);
      end
   end
endtask
task bus(input wr, input [3:0] idx, input [7:0] wd);
   begin
      @(posedge ref_clk);
      avs_address <= {idx, 2'h0};
      avs_writedata <= {24'h00_0000, wd};
      avs_read <= !wr;
      avs_write <= wr;
      @(posedge ref_clk);
      while (avs_waitrequest !== 1'h0) @(posedge ref_clk);
      d = avs_readdata;
      avs_read <= 1'h0;
      avs_write <= 1'h0;
   end
endtask
task rc(input [3:0] idx, input [7:0] x);
   begin
      bus(1'h0, idx, 8'h00);
      chk(d, {24'h00_0000, x});
   end
endtask
task conv(input [9:0] v, input neg);
   begin
      @(posedge ref_clk);
      core_done <= 1'h1;
      core_raw <= v;
      core_negative <= neg;
      @(posedge ref_clk);
      core_done <= 1'h0;
   end
endtask
task trig(input [6:0] f, input [3:0] idx, input [7:0] wd, input integer n);
   begin
      periph_flags <= f;
      starts = 0;
      bus(1'h1, idx, wd);
      repeat (6) @(posedge ref_clk);
      chk(starts, n);
      // finish the started conversion so busy does not hide later triggers
      if (n != 0) conv(core_raw, 1'h0);
   end
endtask
function [15:0] fmt(input [9:0] v, input la);
   fmt = la ? {v, 6'h00} : {6'h00, v};
endfunction
initial begin
   ref_clk = 0;
   forever #4 ref_clk = ~ref_clk;
end
always @(posedge ref_clk) begin
   if (core_start === 1'h1) starts = starts + 1;
   cyc = cyc + 1;
   if (cyc == 20000) begin
      errors = errors + 1;
      close_out;
   end
end
initial begin
   {rst_n, avs_read, avs_write, core_done, core_negative} = 0;
   {avs_address, avs_writedata, core_raw, periph_flags, pin_raw} = 0;
   errors = 0; n_tests = 0; cyc = 0; starts = 0; seed = 32'haab0_666a;
   repeat (10) @(posedge ref_clk);
   rst_n <= 1'h1;
   rc(1, 8'h00); rc(3, 8'h00); rc(4, 8'h00); rc(5, 8'h00);
   chk(avs_response, 0);
   bus(1'h0, 2, 8'h00);
   chk(avs_response, 2);
   for (i = 0; i < 8; i = i + 1) begin
      w = (i == 0) ? 8'hff : $random(seed);
      pin_raw <= $random(seed);
      bus(1'h1, 3, w); rc(3, w);
      bus(1'h1, 1, w); rc(1, w);
      chk(pin_input_disable_bits, w);
      repeat (3) @(posedge ref_clk);
      chk(pin_input, pin_raw & ~w);
   end
   bus(1'h1, 6, 8'h01);
   for (i = 0; i < 4; i = i + 1) begin
      r = $random(seed);
      bus(1'h1, 3, {i[1], 2'h0, i[0], 4'h0});
      bus(1'h1, 7, 8'h01);
      conv(r, i[0]);
      bus(1'h0, 7, 8'h00);
      chk(d[0], 1);
      chk(core_bipolar, i[1]);
      chk(core_enable, 1);
      e = fmt((i == 1) ? 10'h3ff : r, i[0]); // unipolar below zero reads full scale 3ff
      rc(4, e[7:0]); rc(5, e[15:8]);
   end
   bus(1'h1, 3, 8'h00);
   e = fmt(r, 0);
   rc(4, e[7:0]); rc(5, e[15:8]);
   rc(4, e[7:0]);
   bus(1'h1, 7, 8'h01);
   conv(~r, 0);
   bus(1'h0, 7, 8'h00);
   chk(d[1:0], 2);
   rc(5, e[15:8]);
   conv(~r, 0);
   e = fmt(~r, 0);
   rc(4, e[7:0]); rc(5, e[15:8]);
   // high-only reads of a left result never lock, so each new result shows
   bus(1'h1, 3, 8'h10);
   conv(r, 0);
   e = fmt(r, 1);
   rc(5, e[15:8]);
   conv(~r, 0);
   e = fmt(~r, 1);
   rc(5, e[15:8]);
   bus(1'h1, 6, 8'h03);
   for (i = 1; i < 8; i = i + 1) begin
      trig(~(7'h01 << (i - 1)), 3, i[7:0], 0);
      trig(7'h7f, 3, i[7:0], 1);
   end
   trig(7'h00, 3, 8'h01, 0);
   conv(r, 0);
   trig(7'h00, 3, 8'h00, 0);
   bus(1'h1, 7, 8'h01);
   starts = 0;
   conv(r, 0);
   repeat (6) @(posedge ref_clk);
   chk(starts, 1);
   conv(r, 0);
   trig(7'h00, 6, 8'h01, 0);
   trig(7'h01, 3, 8'h01, 0);
   trig(7'h02, 6, 8'h03, 0);
   trig(7'h02, 3, 8'h02, 1);
   close_out;
end
endmodule
